// ===== hdl/ccr_pkg.sv
// Shared constants and types of the clock calendar RAM block
package ccr_pkg;
    // Memory map of the timekeeping locations and the last alarm location
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_HUN = 8'h01;
    localparam logic [7:0] A_SEC = 8'h02;
    localparam logic [7:0] A_MIN = 8'h03;
    localparam logic [7:0] A_HR = 8'h04;
    localparam logic [7:0] A_YD = 8'h05;
    localparam logic [7:0] A_WM = 8'h06;
    localparam logic [7:0] A_TMR = 8'h07;
    localparam logic [7:0] A_ALAST = 8'h0f;
    // Fields of control_and_status and of the hours register
    localparam int B_STOP = 7;
    localparam int B_MODE = 4;
    localparam int B_MASK = 3;
    localparam int B_AEN = 2;
    localparam int B_AFL = 1;
    localparam int B_TFL = 0;
    localparam int B_H12 = 7;
    localparam int B_PM = 6;
    // Counting modes
    localparam logic [1:0] M_32K = 2'h0;
    localparam logic [1:0] M_50HZ = 2'h1;
    localparam logic [1:0] M_EVT = 2'h2;
    localparam logic [1:0] M_OFF = 2'h3;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] ACC_RST = 16'h0000;
    // Upper six bits of the bus slave address
    localparam logic [5:0] SLV_BASE = 6'h28;
    // Bits in a data byte and the oscillator divide ratio
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [16:0] OSC_HZ = 17'h08000;
    localparam logic [16:0] TICK_HZ = 17'h00064;
    // Bus slave states and byte phases
    typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_mack} ccr_state_t;
    typedef enum logic [1:0] {ph_addr, ph_word, ph_data} ccr_phase_t;
endpackage

// ===== hdl/ccr_osc_tick.sv
// Oscillator domain: divides or passes pulses into a tick toggle
`timescale 1ns/100ps
`default_nettype none
module ccr_osc_tick (
    // Oscillator domain
    input wire logic osc_event_in,
    input wire logic rst,
    // Counting mode from the register side
    input wire logic [1:0] mode,
    // One toggle per tick
    output logic tick_toggle
);
    typedef struct packed {
        logic [1:0] ma;
        logic [1:0] mb;
        logic [1:0] mc;
        logic [1:0] md;
        logic [15:0] acc;
        logic tog;
    } ccr_osc_t;

    ccr_osc_t st;
    ccr_osc_t n;
    logic [16:0] sum;
    logic [16:0] dif;

    // Fractional divider gives an exact average of one hundred ticks a second
    always_comb begin
        n = st;
        n.ma = mode;
        n.mb = st.ma;
        n.mc = st.mb;
        // A new mode counts once stages two and three agree, so a split capture is dropped
        if (st.mb == st.mc) begin
            n.md = st.mc;
        end
        sum = {1'b0, st.acc} + ccr_pkg::TICK_HZ;
        dif = sum - ccr_pkg::OSC_HZ;
        if (st.md == ccr_pkg::M_32K) begin
            if (sum >= ccr_pkg::OSC_HZ) begin
                n.acc = dif[15:0];
                n.tog = ~st.tog;
            end else begin
                n.acc = sum[15:0];
            end
        end else begin
            n.tog = ~st.tog;
        end
    end

    // State register on the oscillator edge
    always_ff @(posedge osc_event_in or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.acc <= ccr_pkg::ACC_RST;
        end else begin
            st <= n;
        end
    end

    assign tick_toggle = st.tog;
endmodule
`default_nettype wire

// ===== hdl/ccr_top.sv
// Clock calendar with 256 byte RAM behind a two-wire bus slave
// Function
// - Provide 256 bytes of storage, readable and writable over the bus.
// - Word pointer advances by one after every byte written or read.
// - Address pin sets one bit of the slave address.
// - Locations 0 to 7 keep time; 8 to 15 are alarm or storage.
// - Location 0 is the control and status register.
// - Locations 1 to 7 are the timekeeping counters.
// - Locations 8 to 15 are plain storage unless used for alarm.
// - Control selects 32.768 kHz clock, 50 Hz clock or event counting.
// - Clock modes keep hundredths to weekday in BCD, four year calendar.
// - Timer register counts days up to 99.
// - Event mode counts oscillator input pulses; oscillator output left open.
// - Event count is held as six decimal digits.
// - Reading counters copies all of them into capture latches first.
// - Writing one counter leaves every other counter untouched.
// - Interrupt output is open drain, pulled low when active.
// - Power-on reset initialises all internal logic.
// - Hours count in 24 hour or 12 hour form.
// - Hours register top bit selects 12 hour counting.
// - Alarm and timer overflow set flags; enabled flag pulls interrupt low.
// - Flags stay set until cleared by a bus write.
`timescale 1ns/100ps
`default_nettype none
module ccr_top (
    // Clock and power-on reset
    input wire logic ref_clk,
    input wire logic rst,
    // Oscillator pins
    input wire logic osc_event_in,
    output logic osc_drive_out,
    // Two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Address strap
    input wire logic slave_addr_select,
    // Interrupt pin
    output logic int_out,
    output logic int_oe_n
);
    localparam logic [7:0] B00 = 8'h00;
    localparam logic [7:0] B01 = 8'h01;
    localparam logic [7:0] B12 = 8'h12;
    localparam logic [7:0] B23 = 8'h23;
    localparam logic [7:0] B31 = 8'h31;
    localparam logic [7:0] B59 = 8'h59;
    localparam logic [7:0] B99 = 8'h99;
    localparam logic [4:0] HR11 = 5'h11;
    localparam logic [2:0] WD_LAST = 3'h6;

    typedef struct packed {
        logic [255:0][7:0] ram;
        logic [7:1][7:0] cap;
        logic [7:0] ptr;
        logic [7:0] sh;
        logic [3:0] cnt;
        ccr_pkg::ccr_state_t state;
        ccr_pkg::ccr_phase_t phase;
        logic rd;
        logic nack;
        logic [3:0] sa;
        logic [3:0] sb;
        logic [3:0] sc;
        logic [3:0] f;
        logic sda_oe_n;
        logic int_oe_n;
        logic osc_drv;
        logic pin_lo;
    } ccr_regs_t;

    ccr_regs_t st;
    ccr_regs_t n;
    logic tog;
    logic [1:0] cfg_mode;
    logic [3:0] agree;
    logic [3:0] stp;
    logic [1:0] hw;
    logic [8:0] c;
    logic [7:0] h;
    logic [7:0] d;
    logic [7:0] m;
    logic scl_r;
    logic scl_f;
    logic start;
    logic stop;
    logic tick;
    logic run;
    logic hr_carry;
    logic day_carry;
    logic alm_hit;
    logic addr_hit;
    logic do_write;
    logic do_load;
    logic do_cap;
    logic ld;

    // BCD add with wrap to a lower bound above an upper bound
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic [3:0] s);
        logic [4:0] d0;
        logic [3:0] d1;
        logic [7:0] r;
        d0 = {1'b0, v[3:0]} + {1'b0, s};
        d1 = v[7:4];
        if (d0 > 5'h09) begin
            d0 = d0 - 5'h0a;
            d1 = d1 + 4'h1;
        end
        r = {d1, d0[3:0]};
        if (r > hi) begin
            return {1'b1, lo};
        end
        return {1'b0, r};
    endfunction

    // Last date of a BCD month
    function automatic logic [7:0] dim(input logic [4:0] mon, input logic leap);
        case (mon)
            5'h02: return leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
            default: return B31;
        endcase
    endfunction

    // Read data: counters come from the capture latches, year and weekday maskable
    function automatic logic [7:0] rd_byte(input ccr_regs_t s);
        logic [7:0] v;
        logic msk;
        msk = s.ram[0][ccr_pkg::B_MASK];
        if (s.ptr >= ccr_pkg::A_HUN && s.ptr <= ccr_pkg::A_TMR) begin
            v = s.cap[s.ptr[2:0]];
        end else begin
            v = s.ram[s.ptr];
        end
        if (msk && s.ptr == ccr_pkg::A_YD) begin
            v[7:6] = 2'b00;
        end
        if (msk && s.ptr == ccr_pkg::A_WM) begin
            v[7:5] = 3'b000;
        end
        return v;
    endfunction

    // Oscillator domain divider
    ccr_osc_tick u_osc (
        .osc_event_in(osc_event_in),
        .rst(rst),
        .mode(cfg_mode),
        .tick_toggle(tog)
    );

    // Next state: pin synchronisers, counter chain, bus slave
    always_comb begin
        n = st;
        stp = 4'h1;
        hw = 2'b00;
        c = 9'h000;
        h = st.ram[ccr_pkg::A_HR];
        d = st.ram[ccr_pkg::A_YD];
        m = st.ram[ccr_pkg::A_WM];
        hr_carry = 1'b0;
        day_carry = 1'b0;
        alm_hit = 1'b0;
        addr_hit = 1'b0;
        do_write = 1'b0;
        do_load = 1'b0;
        do_cap = 1'b0;
        ld = 1'b0;
        // Three stages; a change counts once stages two and three agree
        n.sa = {tog, slave_addr_select, sda_in, scl_in};
        n.sb = st.sa;
        n.sc = st.sb;
        agree = st.sb ~^ st.sc;
        n.f = (agree & st.sc) | (~agree & st.f);
        scl_r = n.f[0] & ~st.f[0];
        scl_f = ~n.f[0] & st.f[0];
        start = n.f[0] & st.f[0] & st.f[1] & ~n.f[1];
        stop = n.f[0] & st.f[0] & ~st.f[1] & n.f[1];
        tick = n.f[3] ^ st.f[3];
        run = tick & ~st.ram[0][ccr_pkg::B_STOP];

        // Event counter: six BCD digits in locations 1 to 3
        if (run && cfg_mode == ccr_pkg::M_EVT) begin
            c = bcd_inc(st.ram[ccr_pkg::A_HUN], B00, B99, stp);
            n.ram[ccr_pkg::A_HUN] = c[7:0];
            if (c[8]) begin
                c = bcd_inc(st.ram[ccr_pkg::A_SEC], B00, B99, stp);
                n.ram[ccr_pkg::A_SEC] = c[7:0];
                if (c[8]) begin
                    c = bcd_inc(st.ram[ccr_pkg::A_MIN], B00, B99, stp);
                    n.ram[ccr_pkg::A_MIN] = c[7:0];
                end
            end
        end else if (run && cfg_mode != ccr_pkg::M_OFF) begin
            // A 50 Hz pulse is two hundredths
            stp = (cfg_mode == ccr_pkg::M_50HZ) ? 4'h2 : 4'h1;
            c = bcd_inc(st.ram[ccr_pkg::A_HUN], B00, B99, stp);
            n.ram[ccr_pkg::A_HUN] = c[7:0];
            if (c[8]) begin
                c = bcd_inc(st.ram[ccr_pkg::A_SEC], B00, B59, 4'h1);
                n.ram[ccr_pkg::A_SEC] = c[7:0];
                if (c[8]) begin
                    c = bcd_inc(st.ram[ccr_pkg::A_MIN], B00, B59, 4'h1);
                    n.ram[ccr_pkg::A_MIN] = c[7:0];
                    hr_carry = c[8];
                end
            end
        end

        // Hours in 12 or 24 hour form
        if (hr_carry && h[ccr_pkg::B_H12]) begin
            c = bcd_inc({3'b000, h[4:0]}, B01, B12, 4'h1);
            n.ram[ccr_pkg::A_HR] = {h[7:5], c[4:0]};
            if (h[4:0] == HR11) begin
                n.ram[ccr_pkg::A_HR][ccr_pkg::B_PM] = ~h[ccr_pkg::B_PM];
                day_carry = h[ccr_pkg::B_PM];
            end
        end else if (hr_carry) begin
            c = bcd_inc({2'b00, h[5:0]}, B00, B23, 4'h1);
            n.ram[ccr_pkg::A_HR] = {h[7:6], c[5:0]};
            day_carry = c[8];
        end

        // Date, month, year, weekday and the day timer
        if (day_carry) begin
            if ({2'b00, d[5:0]} >= dim(m[4:0], d[7:6] == 2'b00)) begin
                c = bcd_inc({3'b000, m[4:0]}, B01, B12, 4'h1);
                n.ram[ccr_pkg::A_WM][4:0] = c[4:0];
                n.ram[ccr_pkg::A_YD] = {d[7:6] + {1'b0, c[8]}, B01[5:0]};
            end else begin
                c = bcd_inc({2'b00, d[5:0]}, B01, B31, 4'h1);
                n.ram[ccr_pkg::A_YD][5:0] = c[5:0];
            end
            n.ram[ccr_pkg::A_WM][7:5] = (m[7:5] >= WD_LAST) ? 3'h0 : m[7:5] + 3'h1;
            c = bcd_inc(st.ram[ccr_pkg::A_TMR], B00, B99, 4'h1);
            n.ram[ccr_pkg::A_TMR] = c[7:0];
            hw[ccr_pkg::B_TFL] = c[8];
        end

        // Daily alarm: new time against locations 9 to 12
        if (run && st.ram[0][ccr_pkg::B_AEN] && n.ram[4:1] == st.ram[12:9]) begin
            alm_hit = 1'b1;
            hw[ccr_pkg::B_AFL] = 1'b1;
        end

        // Bus slave
        if (stop) begin
            n.state = ccr_pkg::st_idle;
            n.sda_oe_n = 1'b1;
        end else if (start) begin
            n.state = ccr_pkg::st_rx;
            n.phase = ccr_pkg::ph_addr;
            n.cnt = 4'h0;
            n.sda_oe_n = 1'b1;
        end else begin
            unique case (st.state)
                ccr_pkg::st_idle: begin
                    n.cnt = 4'h0;
                end
                ccr_pkg::st_rx: begin
                    if (scl_r) begin
                        n.sh = {st.sh[6:0], n.f[1]};
                        n.cnt = st.cnt + 4'h1;
                    end else if (scl_f && st.cnt == ccr_pkg::BYTE_BITS) begin
                        n.state = ccr_pkg::st_ack;
                        n.sda_oe_n = 1'b0;
                        unique case (st.phase)
                            ccr_pkg::ph_addr: begin
                                addr_hit = st.sh[7:1] == {ccr_pkg::SLV_BASE, st.f[2]};
                                n.rd = st.sh[0];
                                n.phase = ccr_pkg::ph_word;
                                if (!addr_hit) begin
                                    n.state = ccr_pkg::st_idle;
                                    n.sda_oe_n = 1'b1;
                                end else if (st.sh[0]) begin
                                    do_cap = 1'b1;
                                    n.cap = st.ram[7:1];
                                end
                            end
                            ccr_pkg::ph_word: begin
                                n.ptr = st.sh;
                                n.phase = ccr_pkg::ph_data;
                            end
                            ccr_pkg::ph_data: begin
                                do_write = 1'b1;
                                n.ram[st.ptr] = st.sh;
                                n.ptr = st.ptr + 8'h01;
                            end
                        endcase
                    end
                end
                ccr_pkg::st_ack: begin
                    if (scl_f && st.rd) begin
                        ld = 1'b1;
                    end else if (scl_f) begin
                        n.state = ccr_pkg::st_rx;
                        n.cnt = 4'h0;
                        n.sda_oe_n = 1'b1;
                    end
                end
                ccr_pkg::st_tx: begin
                    if (scl_f && st.cnt == ccr_pkg::BYTE_BITS - 4'h1) begin
                        n.state = ccr_pkg::st_mack;
                        n.sda_oe_n = 1'b1;
                    end else if (scl_f) begin
                        n.sh = {st.sh[6:0], 1'b0};
                        n.sda_oe_n = st.sh[6];
                        n.cnt = st.cnt + 4'h1;
                    end
                end
                ccr_pkg::st_mack: begin
                    if (scl_r) begin
                        n.nack = n.f[1];
                    end else if (scl_f && st.nack) begin
                        n.state = ccr_pkg::st_idle;
                    end else if (scl_f) begin
                        ld = 1'b1;
                    end
                end
            endcase
        end

        // Load the next read byte and drive its first bit
        if (ld) begin
            do_load = 1'b1;
            n.sh = rd_byte(st);
            n.ptr = st.ptr + 8'h01;
            n.sda_oe_n = n.sh[7];
            n.state = ccr_pkg::st_tx;
            n.cnt = 4'h0;
        end

        // Hardware set wins over a clearing write
        n.ram[0][1:0] = n.ram[0][1:0] | hw;
        n.int_oe_n = ~(n.ram[0][ccr_pkg::B_AEN] & (|n.ram[0][1:0]));
        n.osc_drv = n.ram[0][ccr_pkg::B_MODE +: 2] != ccr_pkg::M_EVT;
        n.pin_lo = 1'b0;
    end

    // State register; power-on reset clears everything but the pin enables and oscillator drive, which it sets
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.ram[0] <= ccr_pkg::CTRL_RST;
            st.sda_oe_n <= 1'b1;
            st.int_oe_n <= 1'b1;
            st.osc_drv <= 1'b1;
        end else begin
            st <= n;
        end
    end

    // Outputs straight from the state register
    assign cfg_mode = st.ram[0][ccr_pkg::B_MODE +: 2];
    assign osc_drive_out = st.osc_drv;
    assign sda_out = st.pin_lo;
    assign sda_oe_n = st.sda_oe_n;
    assign int_out = st.pin_lo;
    assign int_oe_n = st.int_oe_n;

    // Checks of the block's own behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_rd_addr;
        do_cap;
    endsequence
    sequence s_sec_load;
        do_load && st.ptr == ccr_pkg::A_SEC;
    endsequence
    sequence s_addr_miss;
        st.state == ccr_pkg::st_rx && scl_f && st.cnt == ccr_pkg::BYTE_BITS &&
        st.phase == ccr_pkg::ph_addr && st.sh[1] != st.f[2];
    endsequence

    a_ptr_write: assert property (do_write |=> st.ptr == $past(st.ptr) + 8'h01)
        else $error("pointer not advanced after write");
    a_ptr_read: assert property (do_load |=> st.ptr == $past(st.ptr) + 8'h01)
        else $error("pointer not advanced after read");
    a_ram_store: assert property (do_write && st.ptr > ccr_pkg::A_ALAST
        |=> st.ram[$past(st.ptr)] == $past(st.sh)) else $error("byte not stored");
    a_addr_pin: assert property (s_addr_miss |=> st.state == ccr_pkg::st_idle)
        else $error("wrong pin address answered");
    a_ctrl_write: assert property (do_write && st.ptr == ccr_pkg::A_CTRL
        |=> st.ram[0][7:2] == $past(st.sh[7:2])) else $error("control not written");
    a_cap_all: assert property (s_rd_addr |=> st.cap == $past(st.ram[7:1]))
        else $error("counters not captured");
    a_cap_read: assert property (s_sec_load |=> st.sh == $past(st.cap[2]))
        else $error("counter read not from latch");
    a_cnt_alone: assert property (do_write && !tick && st.ptr == ccr_pkg::A_MIN
        |=> $stable(st.ram[2]) && $stable(st.ram[4])) else $error("other counter changed");
    a_hund_step: assert property (run && cfg_mode == ccr_pkg::M_32K && !do_write &&
        st.ram[1] == 8'h05 |=> st.ram[1] == 8'h06) else $error("hundredths step");
    a_hz50_step: assert property (run && cfg_mode == ccr_pkg::M_50HZ && !do_write &&
        st.ram[1] == 8'h98 |=> st.ram[1] == 8'h00 && st.ram[2] != $past(st.ram[2]))
        else $error("50 Hz step");
    a_evt_carry: assert property (run && cfg_mode == ccr_pkg::M_EVT && !do_write &&
        st.ram[3:1] == 24'h059999 |=> st.ram[3:1] == 24'h060000) else $error("event carry");
    a_hr_24: assert property (hr_carry && !do_write && st.ram[4] == 8'h23
        |=> st.ram[4] == 8'h00 ##0 $changed(st.ram[7])) else $error("24 hour wrap");
    a_hr_12: assert property (hr_carry && !do_write && st.ram[4] == 8'h91
        |=> st.ram[4] == 8'hd2) else $error("12 hour step");
    a_tmr_ovf: assert property (day_carry && !do_write && st.ram[7] == 8'h99
        |=> st.ram[7] == 8'h00 && st.ram[0][0]) else $error("timer overflow");
    a_flag_hold: assert property (st.ram[0][1] && !(do_write && st.ptr == 8'h00)
        |=> st.ram[0][1]) else $error("flag lost");
    a_int_on: assert property (alm_hit && !do_write |=> st.ram[0][1] && !int_oe_n)
        else $error("alarm did not interrupt");
    a_int_off: assert property (!st.ram[0][2] |-> int_oe_n && !int_out)
        else $error("interrupt driven while disabled");
    a_osc_open: assert property (cfg_mode == ccr_pkg::M_EVT |-> !osc_drive_out)
        else $error("oscillator drive in event mode");
endmodule
`default_nettype wire

// ===== test/ccr_bm.sv
// Two-wire bus master model for the clock calendar slave
`timescale 1ns/100ps
`default_nettype none
module ccr_bm #(
    parameter int QTR = 15
) (
    // Pacing clock
    input wire logic ref_clk,
    // Open-drain drives, 1 releases the line to the pull-up
    output logic scl_o,
    output logic sda_o,
    // Resolved data line
    input wire logic sda_line
);
    // Idle bus: both lines released
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Set both lines just after an edge, then hold a quarter bit
    task automatic put(input logic c, input logic d);
        scl_o = c;
        sda_o = d;
        repeat (QTR) @(posedge ref_clk);
        #1;
    endtask
    // Start, also used as repeated start before a read
    task automatic start();
        put(scl_o, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
    endtask
    task automatic stop();
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
    endtask
    // Data only moves while the clock is low
    task automatic bit_io(input logic b, output logic r);
        put(1'b0, b);
        put(1'b1, b);
        r = sda_line;
        put(1'b1, b);
        put(1'b0, b);
    endtask
    // Address byte, then word address, then data
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Last byte of a read is not acknowledged
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

// ===== test/test_ccr_top.sv
// Self-checking bench for the clock calendar RAM block
`timescale 1ns/100ps
`default_nettype none
module test_ccr_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic osc_event_in = 1'b0;
    logic slave_addr_select = 1'b0;
    logic osc_drive_out, sda_out, sda_oe_n, int_out, int_oe_n, scl, sda_m;
    wire logic sda_line;
    int err_total = 0;
    int comparisons = 0;
    // Pull-up line shared by both open-drain drivers
    assign sda_line = sda_m & (sda_oe_n | sda_out);
    ccr_top ccr_top_inst (.ref_clk(ref_clk), .rst(rst), .osc_event_in(osc_event_in),
        .osc_drive_out(osc_drive_out), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .slave_addr_select(slave_addr_select), .int_out(int_out),
        .int_oe_n(int_oe_n));
    ccr_bm ccr_bm_inst (.ref_clk(ref_clk), .scl_o(scl), .sda_o(sda_m), .sda_line(sda_line));
    // System clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Oscillator pulses at the link rate; the pin stands still between bursts
    task automatic pulses(input int n);
        repeat (n) begin
            #62.5 osc_event_in = 1'b1;
            #62.5 osc_event_in = 1'b0;
        end
        repeat (20) @(posedge ref_clk);
        #1;
    endtask
    // Write address byte and word address
    task automatic head(input logic [7:0] w);
        logic ack;
        ccr_bm_inst.start();
        ccr_bm_inst.send({ccr_pkg::SLV_BASE, slave_addr_select, 1'b0}, ack);
        check("addr ack", {7'h0, ack}, 8'h01);
        ccr_bm_inst.send(w, ack);
        check("word ack", {7'h0, ack}, 8'h01);
    endtask
    task automatic wr(input logic [7:0] w, input logic [7:0] d[$]);
        logic ack;
        head(w);
        foreach (d[i]) begin
            ccr_bm_inst.send(d[i], ack);
            check("data ack", {7'h0, ack}, 8'h01);
        end
        ccr_bm_inst.stop();
    endtask
    // Read a run of locations and compare each byte in turn
    task automatic rd(input logic [7:0] w, input logic [7:0] e[$]);
        logic ack;
        logic [7:0] d;
        head(w);
        ccr_bm_inst.start();
        ccr_bm_inst.send({ccr_pkg::SLV_BASE, slave_addr_select, 1'b1}, ack);
        check("read ack", {7'h0, ack}, 8'h01);
        foreach (e[i]) begin
            ccr_bm_inst.recv(i == e.size() - 1, d);
            check($sformatf("loc %h", 8'(w + i)), d, e[i]);
        end
        ccr_bm_inst.stop();
    endtask
    // Watchdog on the whole run
    initial begin
        repeat (95000) @(posedge ref_clk);
        err_total++;
        close_out();
    end
    // Main sequence
    initial begin
        logic ack;
        // Reset for five clocks; the oscillator side clears without edges
        repeat (5) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        check("osc drive", {7'h0, osc_drive_out}, 8'h01);
        check("int pin", {7'h0, int_oe_n}, 8'h01);
        check("int value", {7'h0, int_out}, 8'h00);
        rd(8'h00, '{8'h00});
        wr(8'h10, '{8'ha5, 8'h5a, 8'h3c});
        rd(8'h10, '{8'ha5, 8'h5a, 8'h3c});
        wr(8'hff, '{8'h5a, 8'h30});
        rd(8'hff, '{8'h5a, 8'h30});
        // Event counting with a carry through the low four digits into the fifth
        // A new mode needs four oscillator edges to reach the divider
        wr(8'h00, '{8'h20});
        pulses(4);
        check("osc drive", {7'h0, osc_drive_out}, 8'h00);
        wr(8'h01, '{8'h99, 8'h99, 8'h05});
        pulses(1);
        rd(8'h01, '{8'h00, 8'h00, 8'h06});
        wr(8'h02, '{8'h42});
        rd(8'h01, '{8'h00, 8'h42, 8'h06});
        // Daily alarm on the 50 Hz base, two hundredths per pulse
        wr(8'h00, '{8'h14});
        pulses(4);
        wr(8'h01, '{8'h00, 8'h00, 8'h00, 8'h00});
        wr(8'h09, '{8'h04, 8'h00, 8'h00, 8'h00});
        check("int idle", {7'h0, int_oe_n}, 8'h01);
        pulses(2);
        check("int on", {7'h0, int_oe_n}, 8'h00);
        rd(8'h00, '{8'h16});
        check("int held", {7'h0, int_oe_n}, 8'h00);
        wr(8'h00, '{8'h14});
        check("int off", {7'h0, int_oe_n}, 8'h01);
        rd(8'h01, '{8'h04, 8'h00});
        // Divided crystal tick rolls every counter and overflows the day timer
        wr(8'h00, '{8'h04});
        pulses(4);
        wr(8'h01, '{8'h99, 8'h59, 8'h59, 8'h23, 8'h31, 8'hd2, 8'h99});
        pulses(330);
        check("int timer", {7'h0, int_oe_n}, 8'h00);
        rd(8'h00, '{8'h05});
        rd(8'h01, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h41, 8'h01, 8'h00});
        // Strap selects the low address bit
        ccr_bm_inst.start();
        ccr_bm_inst.send({ccr_pkg::SLV_BASE, 1'b1, 1'b0}, ack);
        check("other addr", {7'h0, ack}, 8'h00);
        ccr_bm_inst.stop();
        slave_addr_select = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        rd(8'h11, '{8'h5a});
        close_out();
    end
endmodule
`default_nettype wire
